// ### rtl/tomc_codec.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Operational orders decode by their three-bit command code field.
// - Command code 001 means trunk state change.
// - Command code 010 means outpulse digits on a trunk.
// - Command code 011 links a pulsing register to a call register.
// - Command code 101 reports start-pulsing signal detected.
// - Low priority maintenance orders split application/controller by application flag.
// - Maintenance bit set means maintenance order.
// - Opcode is three high bits joined with one low bit.
// - Operational replies drive the maintenance bit to zero.
// - Types 001 digit, 010 revertive pulse, 011 fast reseizure.
// - Types 100 prepulse, 110 wink, 111 general reply.
// - Maintenance replies set bit 15.
// - Single-word maintenance replies clear the multi-word flag, bit 14.
// - Application maintenance replies clear the controller flag, bit 13.
// - Single-word payload fills the low 13 bits.
// - Multi-word header sets multi-word flag; data words follow.
// - Header length equals total length including header minus two.
// - Multi-word header carries an eight-bit type field.
// - Multi-word replies always clear the controller flag.
// - Bit 17 of an inbound order is the maintenance indicator.
// - All outbound replies are 16-bit words.
module tomc_codec (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic                     order_strobe,
  output tomc_pkg::tomc_kind_e     order_kind,
  output logic [3:0]               order_opcode,
  output logic [17:0]              order_data,
  output logic [15:0]              reply_word,
  output logic                     reply_valid
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic        wr_full;
  logic        commit;
  logic        mapped_wr;
  logic [4:0]  words_left;
  logic [2:0]  err_flags;
  logic [15:0] reply_count;
  logic [22:0] last_order;
  logic        order_seen;
  logic        order_unused_set;
  logic [2:0]  msg_code;
  logic        msg_code_ok;
  logic [31:0] next_rdata;
  logic        next_rd_ok;
  logic        wr_oper;
  logic        wr_single;
  logic        wr_hdr;
  logic        wr_word;
  logic        wr_order;
  logic [4:0]  hdr_total;
  logic        seq_busy;

  // Decoded reply requests, error causes and status words
  logic [4:0]  hdr_span;
  logic        hdr_ok;
  logic        take_oper;
  logic        take_single;
  logic        take_hdr;
  logic        take_word;
  logic        err_kind_set;
  logic        err_seq_set;
  logic        err_len_set;
  logic [2:0]  err_clear;
  logic [31:0] order_status_word;
  logic [31:0] reply_status_word;

  // Write takes effect once both address and data are held
  // The bvalid term keeps one write from being applied twice
  assign commit    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign mapped_wr = (wr_addr == tomc_pkg::ORDER_IN_ADDR) ||
                     (wr_addr == tomc_pkg::OPER_MSG_ADDR) ||
                     (wr_addr == tomc_pkg::MAINT_SINGLE_ADDR) ||
                     (wr_addr == tomc_pkg::MAINT_HDR_ADDR) ||
                     (wr_addr == tomc_pkg::MAINT_DATA_ADDR) ||
                     (wr_addr == tomc_pkg::REPLY_STATUS_ADDR);
  assign seq_busy  = (words_left != 5'h00);
  assign wr_order  = commit && (wr_addr == tomc_pkg::ORDER_IN_ADDR);
  assign wr_oper   = commit && (wr_addr == tomc_pkg::OPER_MSG_ADDR);
  assign wr_single = commit && (wr_addr == tomc_pkg::MAINT_SINGLE_ADDR);
  assign wr_hdr    = commit && (wr_addr == tomc_pkg::MAINT_HDR_ADDR);
  assign wr_word   = commit && (wr_addr == tomc_pkg::MAINT_DATA_ADDR);
  assign hdr_total = wr_data[20:16];

  // Length field is four bits wide, so totals outside 2..17 cannot be encoded
  assign hdr_span  = hdr_total - tomc_pkg::LEN_BIAS;
  assign hdr_ok    = (hdr_span <= 5'h0f);

  // Accepted reply requests; each needs a full-word write
  assign take_oper   = wr_full && !seq_busy && wr_oper && msg_code_ok;
  assign take_single = wr_full && !seq_busy && wr_single;
  assign take_hdr    = wr_full && !seq_busy && wr_hdr && hdr_ok;
  assign take_word   = wr_full && seq_busy && wr_word;

  // Error causes and the write-one-to-clear mask from software
  // Sequence error: a new message while data words are owed, or a stray data word
  assign err_kind_set = wr_full && wr_oper && !seq_busy && !msg_code_ok;
  assign err_seq_set  = wr_full && ((seq_busy && (wr_oper || wr_single || wr_hdr)) ||
                                    (!seq_busy && wr_word));
  assign err_len_set  = wr_full && wr_hdr && !seq_busy && !hdr_ok;
  assign err_clear    = (commit && wr_full && wr_addr == tomc_pkg::REPLY_STATUS_ADDR) ?
                        wr_data[2:0] : 3'h0;

  // Address channel: take once, hold until the response is accepted
  // Address bits 1:0 are dropped, every register is one aligned word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      wr_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      wr_addr       <= {s_axi_awaddr[7:2], 2'b00};
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Data channel, independent of the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wr_data      <= 32'h0000_0000;
      wr_full      <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wr_data      <= s_axi_wdata;
      wr_full      <= (s_axi_wstrb == 4'hf);    // Strobes are only valid with wvalid
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Partial strobes and unmapped addresses are refused with SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (mapped_wr && wr_full) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Inbound order decode
  // Refused writes never reach here: a full strobe and the address both gate it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      order_strobe     <= 1'b0;
      order_kind       <= tomc_pkg::TOMC_INVALID;
      order_opcode     <= 4'h0;
      order_data       <= 18'h00000;
      last_order       <= 23'h000000;
      order_seen       <= 1'b0;
      order_unused_set <= 1'b0;
    end else begin
      order_strobe <= 1'b0;
      if (wr_order && wr_full) begin
        last_order <= wr_data[22:0];
        order_seen <= 1'b1;
        if (!wr_data[tomc_pkg::MAINT_IND_BIT]) begin
          // Unused bit is reported only; the sender keeps it zero
          order_unused_set <= wr_data[tomc_pkg::UNUSED_BIT];
          order_opcode     <= {1'b0, wr_data[22:20]};
          order_data       <= {wr_data[tomc_pkg::DATA_FIRST_BIT], wr_data[16:0]};
          unique case (wr_data[22:20])
            tomc_pkg::CMD_STATE_CHANGE: begin
              order_kind   <= tomc_pkg::TOMC_STATE_CHANGE;
              order_strobe <= 1'b1;
            end
            tomc_pkg::CMD_DIGIT_OUT: begin
              order_kind   <= tomc_pkg::TOMC_DIGIT_OUT;
              order_strobe <= 1'b1;
            end
            tomc_pkg::CMD_LINK: begin
              order_kind   <= tomc_pkg::TOMC_LINK;
              order_strobe <= 1'b1;
            end
            tomc_pkg::CMD_START_PULSE: begin
              order_kind   <= tomc_pkg::TOMC_START_PULSE;
              order_strobe <= 1'b1;
            end
            default: begin
              order_kind <= tomc_pkg::TOMC_INVALID;
            end
          endcase
        end else begin
          order_unused_set <= 1'b0;
          order_opcode <= {wr_data[20:18], wr_data[tomc_pkg::OPC_LOW_BIT]};
          order_data   <= {2'b00, wr_data[15:0]};
          order_strobe <= 1'b1;
          // Priority zero with application flag set is an application order
          if (!wr_data[tomc_pkg::PRIORITY_BIT] && wr_data[tomc_pkg::APP_ORDER_BIT]) begin
            order_kind <= tomc_pkg::TOMC_MAINT_APP;
          end else begin
            order_kind <= tomc_pkg::TOMC_MAINT_CTRL;
          end
        end
      end
    end
  end

  // Kind index from software to message type code
  always_comb begin
    msg_code_ok = 1'b1;
    unique case (wr_data[18:16])
      3'h0: msg_code = tomc_pkg::MT_DIGIT;
      3'h1: msg_code = tomc_pkg::MT_REVERTIVE;
      3'h2: msg_code = tomc_pkg::MT_RESEIZE;
      3'h3: msg_code = tomc_pkg::MT_PREPULSE;
      3'h4: msg_code = tomc_pkg::MT_WINK;
      3'h5: msg_code = tomc_pkg::MT_GENERAL;
      default: begin
        msg_code    = 3'h0;
        msg_code_ok = 1'b0;
      end
    endcase
  end

  // Outbound reply word builder; every accepted request emits one 16-bit word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reply_word  <= 16'h0000;
      reply_valid <= 1'b0;
      words_left  <= 5'h00;
    end else begin
      reply_valid <= 1'b0;
      if (take_oper) begin
        reply_word  <= {1'b0, msg_code, wr_data[11:0]};
        reply_valid <= 1'b1;
      end else if (take_single) begin
        reply_word  <= {1'b1, 1'b0, 1'b0, wr_data[12:0]};
        reply_valid <= 1'b1;
      end else if (take_hdr) begin
        reply_word  <= {1'b1, 1'b1, 1'b0, 1'b0,
                        hdr_span[3:0],
                        wr_data[7:0]};
        reply_valid <= 1'b1;
        words_left  <= hdr_total - 5'h01;
      end else if (take_word) begin
        reply_word  <= wr_data[15:0];
        reply_valid <= 1'b1;
        words_left  <= words_left - 5'h01;
      end
    end
  end

  // Sticky error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flags <= 3'h0;
    end else begin
      err_flags <= (err_flags & ~err_clear) |
                   {err_len_set, err_seq_set, err_kind_set};
    end
  end

  // Count of reply words emitted
  // Wraps after 65536 words; software treats it as a running tally
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reply_count <= 16'h0000;
    end else if (reply_valid) begin
      reply_count <= reply_count + 16'h0001;
    end
  end

  // Status words as software reads them
  assign order_status_word = {20'h00000, order_seen, order_unused_set,
                              last_order[tomc_pkg::MAINT_IND_BIT], 2'b00, order_kind,
                              order_opcode};
  assign reply_status_word = {reply_count, reply_word[15:8], words_left, err_flags};

  // Read data selection
  always_comb begin
    next_rd_ok = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      tomc_pkg::ORDER_IN_ADDR:
        next_rdata = {9'h000, last_order};
      tomc_pkg::ORDER_STATUS_ADDR:
        next_rdata = order_status_word;
      tomc_pkg::ORDER_DATA_ADDR:
        next_rdata = {14'h0000, order_data};
      tomc_pkg::REPLY_STATUS_ADDR:
        next_rdata = reply_status_word;
      tomc_pkg::OPER_MSG_ADDR, tomc_pkg::MAINT_SINGLE_ADDR,
      tomc_pkg::MAINT_HDR_ADDR, tomc_pkg::MAINT_DATA_ADDR:
        next_rdata = 32'h0000_0000;
      default:
        next_rd_ok = 1'b0;
    endcase
  end

  // Read channel: one read in flight, answered the cycle after it is taken
  // No new address is taken until the data has been accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### rtl/tomc_pkg.sv
package tomc_pkg;

  // Register byte offsets
  localparam logic [7:0] ORDER_IN_ADDR     = 8'h00;
  localparam logic [7:0] ORDER_STATUS_ADDR = 8'h04;
  localparam logic [7:0] ORDER_DATA_ADDR   = 8'h08;
  localparam logic [7:0] OPER_MSG_ADDR     = 8'h0c;
  localparam logic [7:0] MAINT_SINGLE_ADDR = 8'h10;
  localparam logic [7:0] MAINT_HDR_ADDR    = 8'h14;
  localparam logic [7:0] MAINT_DATA_ADDR   = 8'h18;
  localparam logic [7:0] REPLY_STATUS_ADDR = 8'h1c;

  // Inbound order fields
  localparam int ORDER_W        = 23;
  localparam int CMD_LSB        = 20;
  localparam int UNUSED_BIT     = 19;
  localparam int DATA_FIRST_BIT = 18;
  localparam int MAINT_IND_BIT  = 17;
  localparam int PRIORITY_BIT   = 22;
  localparam int APP_ORDER_BIT  = 21;
  localparam int OPC_HIGH_LSB   = 18;
  localparam int OPC_LOW_BIT    = 16;

  // Command codes of operational orders
  localparam logic [2:0] CMD_STATE_CHANGE = 3'h1;
  localparam logic [2:0] CMD_DIGIT_OUT    = 3'h2;
  localparam logic [2:0] CMD_LINK         = 3'h3;
  localparam logic [2:0] CMD_START_PULSE  = 3'h5;

  // Outbound message fields
  localparam int REPLY_W        = 16;
  localparam int MAINT_MSG_BIT  = 15;
  localparam int MULTIWORD_BIT  = 14;
  localparam int CTRL_MSG_BIT   = 13;
  localparam int MSG_TYPE_LSB   = 12;
  localparam int HDR_LEN_LSB    = 8;
  localparam logic [4:0] LEN_BIAS = 5'h02;

  // Operational message type codes
  localparam logic [2:0] MT_DIGIT     = 3'h1;
  localparam logic [2:0] MT_REVERTIVE = 3'h2;
  localparam logic [2:0] MT_RESEIZE   = 3'h3;
  localparam logic [2:0] MT_PREPULSE  = 3'h4;
  localparam logic [2:0] MT_WINK      = 3'h6;
  localparam logic [2:0] MT_GENERAL   = 3'h7;

  // Reply status error bits
  localparam int ERR_KIND_BIT = 0;
  localparam int ERR_SEQ_BIT  = 1;
  localparam int ERR_LEN_BIT  = 2;

  typedef enum logic [2:0] {
    TOMC_STATE_CHANGE,
    TOMC_DIGIT_OUT,
    TOMC_LINK,
    TOMC_START_PULSE,
    TOMC_INVALID,
    TOMC_MAINT_APP,
    TOMC_MAINT_CTRL
  } tomc_kind_e;

endpackage

// ### tb/tomc_codec_chk.sv
`timescale 1ns/1ps
// Watches the decoded orders and the reply words against the last bus write
module tomc_codec_chk (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [7:0]           s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [31:0]          s_axi_wdata,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 order_strobe,
  input wire tomc_pkg::tomc_kind_e order_kind,
  input wire logic [3:0]           order_opcode,
  input wire logic [17:0]          order_data,
  input wire logic [15:0]          reply_word,
  input wire logic                 reply_valid
);
  logic [7:0]  adr;
  logic [31:0] dat;
  logic [4:0]  len_m2;

  // Capture address and data of the write under way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adr <= 8'h00;
      dat <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) adr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) dat <= s_axi_wdata;
    end
  end

  // Header length field, total minus two
  assign len_m2 = dat[20:16] - 5'h02;

  // Kind expected for a command code
  function automatic tomc_pkg::tomc_kind_e kind_of(input logic [2:0] c);
    case (c)
      3'h1: return tomc_pkg::TOMC_STATE_CHANGE;
      3'h2: return tomc_pkg::TOMC_DIGIT_OUT;
      3'h3: return tomc_pkg::TOMC_LINK;
      3'h5: return tomc_pkg::TOMC_START_PULSE;
      default: return tomc_pkg::TOMC_INVALID;
    endcase
  endfunction

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  oper_decode_a: assert property (
    order_strobe && !dat[17] |-> order_kind == kind_of(dat[22:20])
      && order_opcode == {1'b0, dat[22:20]} && order_data == {dat[18], dat[16:0]})
    else $error("operational order decoded wrongly");
  maint_class_a: assert property (
    order_strobe |-> dat[17] == (order_kind inside {tomc_pkg::TOMC_MAINT_APP,
      tomc_pkg::TOMC_MAINT_CTRL})) else $error("order class wrong");
  opcode_join_a: assert property (
    order_strobe && dat[17] |-> order_opcode == {dat[20:18], dat[16]}
      && order_data == {2'b00, dat[15:0]}) else $error("maintenance opcode wrong");
  app_split_a: assert property (
    order_strobe && dat[17] |-> (order_kind == tomc_pkg::TOMC_MAINT_APP) == (!dat[22] && dat[21]))
    else $error("application split wrong");
  strobe_cause_a: assert property (
    $rose(s_axi_bvalid) && s_axi_bresp == 2'b00 && adr[7:2] == 6'h00 |-> order_strobe
      == (dat[17] || kind_of(dat[22:20]) != tomc_pkg::TOMC_INVALID)) else $error("strobe wrong");
  oper_msg_a: assert property (
    reply_valid && adr[7:2] == 6'h03 |-> reply_word == {1'b0, (dat[18:16] < 3'h4) ?
      dat[18:16] + 3'h1 : dat[18:16] + 3'h2, dat[11:0]}) else $error("operational reply wrong");
  single_msg_a: assert property (
    reply_valid && adr[7:2] == 6'h04 |-> reply_word == {3'b100, dat[12:0]})
    else $error("single maintenance reply wrong");
  header_msg_a: assert property (
    reply_valid && adr[7:2] == 6'h05 |-> reply_word == {4'b1100, len_m2[3:0], dat[7:0]})
    else $error("header word wrong");
  data_word_a: assert property (
    reply_valid && adr[7:2] == 6'h06 |-> reply_word == dat[15:0]) else $error("data word wrong");
  pulse_time_a: assert property (
    reply_valid || order_strobe |-> $rose(s_axi_bvalid) ##1 !reply_valid && !order_strobe)
    else $error("output pulse timing wrong");
endmodule

bind tomc_codec tomc_codec_chk chk (.*);

// ### tb/tomc_cpu_model.sv
`timescale 1ns/1ps
// Central processor side of the register bus, one write and one read at a time
module tomc_cpu_model (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus; answers are always accepted at once
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
  end

  // Write: each channel released when taken, payload then scrambled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
        s_axi_wstrb <= ~s;
      end
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  // Read: address released when taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// ### tb/tomc_codec_tb.sv
`timescale 1ns/1ps
module tomc_codec_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, order_strobe, reply_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, q_rep[$], q_ord[$];
  logic [3:0]  s_axi_wstrb, order_opcode;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [17:0] order_data;
  logic [15:0] reply_word;
  logic [2:0]  mt_tab [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  int          n_fail, num_checks;
  tomc_pkg::tomc_kind_e order_kind;

  tomc_codec uut (.*);
  tomc_cpu_model cpu (.*);

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic tomc_pkg::tomc_kind_e ekind(input logic [2:0] c);
    case (c)
      3'h1: return tomc_pkg::TOMC_STATE_CHANGE;
      3'h2: return tomc_pkg::TOMC_DIGIT_OUT;
      3'h3: return tomc_pkg::TOMC_LINK;
      3'h5: return tomc_pkg::TOMC_START_PULSE;
      default: return tomc_pkg::TOMC_INVALID;
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    cpu.wr(a, d, s, r);
    check("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic br(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                    input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  r;
    cpu.rd(a, v, r);
    check("rdata", v & m, exp);
    check("rresp", {30'h0, r}, {30'h0, er});
  endtask

  // Oldest expected word against each pulse seen at the outputs
  always @(posedge aclk) begin
    if (reply_valid) check("reply", {16'h0, reply_word}, q_rep.size() ? q_rep.pop_front() : '1);
    if (order_strobe) check("order", {7'h0, order_kind, order_opcode, order_data},
                            q_ord.size() ? q_ord.pop_front() : '1);
  end

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #50000;
    n_fail++;
    summarize();
  end

  initial begin
    logic [31:0] o;
    logic [2:0]  c;
    int          k;
    rnd = 32'h6ebc8934;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Operational orders with every command code; unused and indicator bits clear
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      c = k[2:0];
      o = {9'h0, c, 1'b0, rnd[18], 1'b0, rnd[16:0]};
      if (ekind(c) != tomc_pkg::TOMC_INVALID) q_ord.push_back({7'h0, ekind(c), 1'b0, c, rnd[18], rnd[16:0]});
      bw(tomc_pkg::ORDER_IN_ADDR, o, 4'hf, 2'b00);
      br(tomc_pkg::ORDER_STATUS_ADDR, {25'h0, ekind(c), 4'h0}, 32'h70, 2'b00);
    end
    br(tomc_pkg::ORDER_IN_ADDR, o, 32'h7fffff, 2'b00);
    // Maintenance orders over all priority and application combinations
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      q_ord.push_back({7'h0, (k == 1) ? tomc_pkg::TOMC_MAINT_APP : tomc_pkg::TOMC_MAINT_CTRL,
                       rnd[20:18], rnd[16], 2'b00, rnd[15:0]});
      bw(tomc_pkg::ORDER_IN_ADDR, {9'h0, k[1], k[0], rnd[20:18], 1'b1, rnd[16:0]}, 4'hf, 2'b00);
    end
    br(tomc_pkg::ORDER_DATA_ADDR, {16'h0, rnd[15:0]}, 32'h3ffff, 2'b00);
    br(tomc_pkg::ORDER_STATUS_ADDR, {20'h0, 3'b101, 2'b00, tomc_pkg::TOMC_MAINT_CTRL,
                                     rnd[20:18], rnd[16]}, 32'hfff, 2'b00);
    // Operational messages of every type index; two spare indexes are refused
    for (k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      if (k < 6) q_rep.push_back({16'h0, 1'b0, mt_tab[k], rnd[11:0]});
      bw(tomc_pkg::OPER_MSG_ADDR, {13'h0, k[2:0], 4'h0, rnd[11:0]}, 4'hf, 2'b00);
      if (k >= 6) begin
        br(tomc_pkg::REPLY_STATUS_ADDR, 32'h1, 32'h1, 2'b00);
        bw(tomc_pkg::REPLY_STATUS_ADDR, 32'h7, 4'hf, 2'b00);
        br(tomc_pkg::REPLY_STATUS_ADDR, 32'h0, 32'h7, 2'b00);
      end
    end
    // Single-word maintenance message
    rnd = lfsr(rnd);
    q_rep.push_back({16'h0, 3'b100, rnd[12:0]});
    bw(tomc_pkg::MAINT_SINGLE_ADDR, {19'h0, rnd[12:0]}, 4'hf, 2'b00);
    // Multi-word messages at the shortest and longest totals
    for (k = 2; k < 18; k += 15) begin
      rnd = lfsr(rnd);
      q_rep.push_back({16'h0, 4'b1100, k[3:0] - 4'h2, rnd[7:0]});
      bw(tomc_pkg::MAINT_HDR_ADDR, {11'h0, k[4:0], 8'h0, rnd[7:0]}, 4'hf, 2'b00);
      br(tomc_pkg::REPLY_STATUS_ADDR, {24'h0, k[4:0] - 5'h1, 3'h0}, 32'hf8, 2'b00);
      repeat (k - 1) begin
        rnd = lfsr(rnd);
        q_rep.push_back({16'h0, rnd[15:0]});
        bw(tomc_pkg::MAINT_DATA_ADDR, {16'h0, rnd[15:0]}, 4'hf, 2'b00);
      end
    end
    // Data word with none expected, unmapped places and a partial strobe
    bw(tomc_pkg::MAINT_DATA_ADDR, 32'h1234, 4'hf, 2'b00);
    br(tomc_pkg::REPLY_STATUS_ADDR, 32'h2, 32'h2, 2'b00);
    bw(tomc_pkg::MAINT_HDR_ADDR, 32'h00120000, 4'hf, 2'b00);
    br(tomc_pkg::REPLY_STATUS_ADDR, 32'h4, 32'h4, 2'b00);
    bw(8'h20, 32'h0, 4'hf, 2'b10);
    bw(tomc_pkg::ORDER_IN_ADDR, 32'h00120000, 4'h3, 2'b10);
    br(8'h24, 32'h0, 32'hffffffff, 2'b10);
    // Reset in mid-run returns the status to its idle values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    br(tomc_pkg::ORDER_STATUS_ADDR, 32'h40, 32'h870, 2'b00);
    br(tomc_pkg::REPLY_STATUS_ADDR, 32'h0, 32'hff, 2'b00);
    repeat (3) @(posedge aclk);
    check("left", 32'(q_rep.size() + q_ord.size()), 32'h0);
    summarize();
  end
endmodule
